// ==== src/arc_pkg.sv ====
// Constants, types and field layout for the acquisition control block
//==========================================================================
// What this block does
// - Keep values at or above channel threshold
// - Below threshold: drop, or keep flagged bit 13
// - Step zero: compare top 8 bits
// - Step one: compare bits 1-8, 9-11 zero
// - Kill bit blocks channel storage
// - Thresholds survive every reset type
// - Overflow dropped unless kept, flagged bit 12
// - Buffer of 32 events, 34 words each
// - Write pointer auto, read pointer auto or dummy
// - Not-empty, Full, Empty from pointer history
// - Event is header, data words, end word
// - Empty-event keep stores two-word event
// - 24-bit gate counter, all or accepted
// - Count in end word and two registers
// - Busy drives pin and status bits 2, 3
// - Busy from gate edge, further gates ignored
// - Stop on chain busy or local busy
// - Data reset clears buffer, pointers, counter
// - Software reset adds soft register clearing
// - Hardware reset also clears remaining registers
// - Fast clear in window aborts conversion
// - Gates rejected 600 ns after fast clear
package arc_pkg;

  //==========================================================================
  // Sizes
  localparam int unsigned NUM_CHAN   = 32;
  localparam int unsigned NUM_EVENTS = 32;
  localparam int unsigned SLOT_WORDS = 34;

  //==========================================================================
  // Register offsets
  localparam logic [15:0] OFS_EVENT_BUF     = 16'h0000;
  localparam logic [15:0] OFS_EVENT_BUF_END = 16'h07FC;
  localparam logic [15:0] OFS_THRESH        = 16'h1080;
  localparam logic [15:0] OFS_THRESH_END    = 16'h10BF;
  localparam logic [15:0] OFS_STATUS1       = 16'h1000;
  localparam logic [15:0] OFS_BIT_SET1      = 16'h1004;
  localparam logic [15:0] OFS_BIT_CLEAR1    = 16'h1008;
  localparam logic [15:0] OFS_CONTROL1      = 16'h100C;
  localparam logic [15:0] OFS_SINGLE_RESET  = 16'h1010;
  localparam logic [15:0] OFS_GATE_CNT_LOW  = 16'h1014;
  localparam logic [15:0] OFS_GATE_CNT_HIGH = 16'h1018;
  localparam logic [15:0] OFS_NEXT_EVENT    = 16'h101C;
  localparam logic [15:0] OFS_NEXT_WORD     = 16'h1020;
  localparam logic [15:0] OFS_FC_WINDOW     = 16'h1024;
  localparam logic [15:0] OFS_BIT_SET2      = 16'h1028;
  localparam logic [15:0] OFS_BIT_CLEAR2    = 16'h102C;

  //==========================================================================
  // Field positions
  localparam int unsigned BS1_SW_RESET_BIT     = 7;
  localparam int unsigned CR1_PANEL_SEL_BIT    = 4;
  localparam int unsigned BS2_MEM_TEST_BIT     = 0;
  localparam int unsigned BS2_CLEAR_DATA_BIT   = 2;
  localparam int unsigned BS2_OVF_KEEP_BIT     = 3;
  localparam int unsigned BS2_BELOW_KEEP_BIT   = 4;
  localparam int unsigned BS2_STEP_BIT         = 8;
  localparam int unsigned BS2_AUTO_ADV_BIT     = 11;
  localparam int unsigned BS2_EMPTY_KEEP_BIT   = 12;
  localparam int unsigned BS2_COUNT_ALL_BIT    = 14;
  localparam int unsigned ST1_READY_BIT        = 0;
  localparam int unsigned ST1_BUSY_BIT         = 2;
  localparam int unsigned ST1_GLOBAL_BUSY_BIT  = 3;
  localparam int unsigned ST1_FULL_BIT         = 4;
  localparam int unsigned ST1_EMPTY_BIT        = 5;
  localparam int unsigned THR_KILL_BIT         = 8;
  localparam int unsigned WORD_TAG_LSB         = 24;
  localparam int unsigned DATA_CHAN_LSB        = 16;
  localparam int unsigned DATA_UNDER_BIT       = 13;
  localparam int unsigned DATA_OVF_BIT         = 12;
  localparam int unsigned HDR_COUNT_LSB        = 8;
  localparam logic [2:0]  TAG_DATA             = 3'h0;
  localparam logic [2:0]  TAG_HEADER           = 3'h2;
  localparam logic [2:0]  TAG_EOB              = 3'h4;
  localparam logic [2:0]  TAG_INVALID          = 3'h6;

  //==========================================================================
  // Reset values
  localparam logic [15:0] BS1_RESET = 16'h0000;
  localparam logic [15:0] CR1_RESET = 16'h0000;
  localparam logic [15:0] BS2_RESET = 16'h4000;
  localparam logic [15:0] FCW_RESET = 16'h00C8;

  //==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned CLEAR_NS     = 600;
  localparam int unsigned CLEAR_CYCLES = (CLEAR_NS * CLK_MHZ + 999) / 1000;

  //==========================================================================
  // Types
  typedef struct packed {
    logic        overflow;
    logic [4:0]  chan;
    logic [11:0] value;
  } arc_conv_s;

  typedef enum {ST_IDLE, ST_GATE, ST_CONV, ST_HDR, ST_EOB, ST_CLEAR} arc_state_e;

endpackage : arc_pkg

// ==== src/arc_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module arc_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          s1_ff[g]   <= 1'b0;
          s2_ff[g]   <= 1'b0;
          s3_ff[g]   <= 1'b0;
          o_level[g] <= 1'b0;
        end else if (i_ce) begin
          s1_ff[g] <= i_pin[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          // Only a level seen twice counts, first stage stays private
          if (s2_ff[g] == s3_ff[g]) begin
            o_level[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

endmodule : arc_pin_sync

// ==== src/arc_acq_ctrl.sv ====
// Acquisition control: filtering, event buffer, gate counter, busy, resets, fast clear
`timescale 1ns/10ps
module arc_acq_ctrl
  import arc_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_gate,
  input  wire logic        i_veto,
  input  wire logic        i_fast_clear_input,
  input  wire logic        i_panel_reset,
  input  wire logic        i_busy_line,
  input  wire logic        i_stop_scope_jumper,
  input  wire logic        i_conv_valid,
  input  wire arc_conv_s   i_conv,
  input  wire logic        i_conv_done,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_ack,
  output logic             o_busy_out,
  output logic             o_busy_oe,
  output logic             o_data_ready,
  output logic             o_conv_start,
  output logic             o_peak_clear
);

  //==========================================================================
  // Pin synchronisation
  logic [5:0] pins_s;
  logic gate_s, veto_s, fast_clear_input_s, prst_s, chain_busy_s, chain_sel_s;
  logic gate_d_ff, fast_clear_input_d_ff, prst_d_ff;

  arc_pin_sync #(.W(6)) u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_pin   ({i_stop_scope_jumper, i_busy_line, i_panel_reset, i_fast_clear_input, i_veto, i_gate}),
    .o_level (pins_s)
  );
  assign {chain_sel_s, chain_busy_s, prst_s, fast_clear_input_s, veto_s, gate_s} = pins_s;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gate_d_ff <= 1'b0;
      fast_clear_input_d_ff <= 1'b0;
      prst_d_ff <= 1'b0;
    end else if (i_ce) begin
      gate_d_ff <= gate_s;
      fast_clear_input_d_ff <= fast_clear_input_s;
      prst_d_ff <= prst_s;
    end
  end

  logic gate_rise, fast_clear_input_rise, prst_rise;
  assign gate_rise = gate_s & ~gate_d_ff;
  assign fast_clear_input_rise = fast_clear_input_s & ~fast_clear_input_d_ff;
  assign prst_rise = prst_s & ~prst_d_ff;

  //==========================================================================
  // Control registers
  logic [15:0] bs1_ff, cr1_ff, bs2_ff, fcw_ff;
  logic        sw_rst, data_rst;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction : hit

  logic wr_en, rd_en;
  assign wr_en = i_ce & i_reg_wr;
  assign rd_en = i_ce & i_reg_rd;

  // Single-shot reset lasts only while the write is held
  assign sw_rst   = bs1_ff[BS1_SW_RESET_BIT] | (prst_rise & cr1_ff[CR1_PANEL_SEL_BIT])
                  | (i_reg_wr & hit(i_reg_addr, OFS_SINGLE_RESET));
  assign data_rst = sw_rst | bs2_ff[BS2_CLEAR_DATA_BIT]
                  | (prst_rise & ~cr1_ff[CR1_PANEL_SEL_BIT]);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bs1_ff <= BS1_RESET;
      cr1_ff <= CR1_RESET;
    end else if (wr_en) begin
      if (hit(i_reg_addr, OFS_BIT_SET1)) bs1_ff <= bs1_ff | i_reg_wdata;
      if (hit(i_reg_addr, OFS_BIT_CLEAR1)) bs1_ff <= bs1_ff & ~i_reg_wdata;
      if (hit(i_reg_addr, OFS_CONTROL1)) cr1_ff <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bs2_ff <= BS2_RESET;
      fcw_ff <= FCW_RESET;
    end else if (i_ce) begin
      if (sw_rst) begin
        bs2_ff <= BS2_RESET;
        fcw_ff <= FCW_RESET;
      end else if (i_reg_wr) begin
        if (hit(i_reg_addr, OFS_BIT_SET2)) bs2_ff <= bs2_ff | i_reg_wdata;
        if (hit(i_reg_addr, OFS_BIT_CLEAR2)) bs2_ff <= bs2_ff & ~i_reg_wdata;
        if (hit(i_reg_addr, OFS_FC_WINDOW)) fcw_ff <= i_reg_wdata;
      end
    end
  end

  // Thresholds have no reset at all; contents undefined until written
  logic [15:0] thr_mem [NUM_CHAN];
  logic        thr_wr;
  assign thr_wr = wr_en & (i_reg_addr >= OFS_THRESH) & (i_reg_addr <= OFS_THRESH_END);
  always_ff @(posedge i_mclk) begin
    if (thr_wr) thr_mem[i_reg_addr[5:1]] <= i_reg_wdata;
  end

  //==========================================================================
  // Zero and overflow suppression
  logic [15:0] thr_entry;
  logic        under, keep_value;
  assign thr_entry = thr_mem[i_conv.chan];
  always_comb begin
    if (bs2_ff[BS2_STEP_BIT]) begin
      under = (i_conv.value[8:1] < thr_entry[7:0]) && (i_conv.value[11:9] == 3'h0);
    end else begin
      under = i_conv.value[11:4] < thr_entry[7:0];
    end
  end
  assign keep_value = ~thr_entry[THR_KILL_BIT]
                    & (~i_conv.overflow | bs2_ff[BS2_OVF_KEEP_BIT])
                    & (~under | bs2_ff[BS2_BELOW_KEEP_BIT]);

  //==========================================================================
  // Pointers and buffer state
  logic [4:0] wp_ff, rp_ev_ff;
  logic [5:0] rp_word_ff;
  logic       last_wr_ff, full, empty, wp_adv, rp_adv_ev, rp_adv_word;
  logic [5:0] len_ff [NUM_EVENTS];

  assign full  = (wp_ff == rp_ev_ff) & last_wr_ff;
  assign empty = (wp_ff == rp_ev_ff) & ~last_wr_ff;

  logic buf_rd, auto_step;
  assign buf_rd    = rd_en & (i_reg_addr <= OFS_EVENT_BUF_END);
  assign auto_step = buf_rd & bs2_ff[BS2_AUTO_ADV_BIT];
  assign rp_adv_word = ~empty & (auto_step | (wr_en & hit(i_reg_addr, OFS_NEXT_WORD)));
  assign rp_adv_ev   = (~empty & wr_en & hit(i_reg_addr, OFS_NEXT_EVENT))
                     | (rp_adv_word & (rp_word_ff >= len_ff[rp_ev_ff] - 6'h01));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wp_ff      <= 5'h00;
      rp_ev_ff   <= 5'h00;
      rp_word_ff <= 6'h00;
      last_wr_ff <= 1'b0;
    end else if (i_ce) begin
      if (data_rst) begin
        wp_ff      <= 5'h00;
        rp_ev_ff   <= 5'h00;
        rp_word_ff <= 6'h00;
        last_wr_ff <= 1'b0;
      end else begin
        if (wp_adv) wp_ff <= wp_ff + 5'h01;
        if (rp_adv_ev) begin
          rp_ev_ff   <= rp_ev_ff + 5'h01;
          rp_word_ff <= 6'h00;
        end else if (rp_adv_word) begin
          rp_word_ff <= rp_word_ff + 6'h01;
        end
        if (wp_adv) last_wr_ff <= 1'b1;
        else if (rp_adv_ev) last_wr_ff <= 1'b0;
      end
    end
  end

  //==========================================================================
  // Busy and gate acceptance
  arc_state_e  state_ff;
  logic        busy, stop, gate_accept, fc_hit;
  logic [15:0] win_cnt_ff;
  logic [23:0] gate_cnt_ff;

  // Busy chain line also carries our own drive, harmless for the wired OR
  assign busy = (state_ff != ST_IDLE) | data_rst | full | bs2_ff[BS2_MEM_TEST_BIT];
  assign stop = busy | (chain_sel_s & chain_busy_s);
  assign gate_accept = gate_rise & ~stop & ~veto_s & ~fast_clear_input_s;
  assign fc_hit = fast_clear_input_rise & (win_cnt_ff < fcw_ff)
                & ((state_ff == ST_GATE) | (state_ff == ST_CONV));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gate_cnt_ff <= 24'h000000;
    end else if (i_ce) begin
      if (data_rst) gate_cnt_ff <= 24'h000000;
      else if (gate_rise & (bs2_ff[BS2_COUNT_ALL_BIT] | gate_accept)) gate_cnt_ff <= gate_cnt_ff + 24'h000001;
    end
  end

  //==========================================================================
  // Conversion sequencer
  logic [5:0]  n_ff;
  logic [7:0]  clr_cnt_ff;
  logic        mem_we;
  logic [5:0]  mem_wofs;
  logic [31:0] mem_wdata;
  logic        data_take;

  assign data_take = (state_ff == ST_CONV) & ~fc_hit & ~data_rst & i_conv_valid & keep_value
                   & (n_ff < 6'(NUM_CHAN));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff     <= ST_IDLE;
      n_ff         <= 6'h00;
      win_cnt_ff   <= 16'h0000;
      clr_cnt_ff   <= 8'h00;
      o_conv_start <= 1'b0;
    end else if (i_ce) begin
      o_conv_start <= 1'b0;
      if (win_cnt_ff != 16'hFFFF) win_cnt_ff <= win_cnt_ff + 16'h0001;
      if (data_rst) begin
        state_ff <= ST_IDLE;
        n_ff     <= 6'h00;
      end else begin
        unique case (state_ff)
          ST_IDLE: if (gate_accept) begin
            state_ff   <= ST_GATE;
            win_cnt_ff <= 16'h0000;
          end
          ST_GATE: if (fc_hit) begin
            state_ff   <= ST_CLEAR;
            clr_cnt_ff <= 8'h00;
          end else if (!gate_s) begin
            state_ff     <= ST_CONV;
            n_ff         <= 6'h00;
            o_conv_start <= 1'b1;
          end
          ST_CONV: if (fc_hit) begin
            state_ff   <= ST_CLEAR;
            clr_cnt_ff <= 8'h00;
          end else begin
            if (data_take) n_ff <= n_ff + 6'h01;
            if (i_conv_done) state_ff <= ST_HDR;
          end
          ST_HDR: state_ff <= ST_EOB;
          ST_EOB: begin
            state_ff   <= ST_CLEAR;
            clr_cnt_ff <= 8'h00;
          end
          ST_CLEAR: if (clr_cnt_ff == 8'(CLEAR_CYCLES - 1)) state_ff <= ST_IDLE;
          else clr_cnt_ff <= clr_cnt_ff + 8'h01;
        endcase
      end
    end
  end

  assign wp_adv = i_ce & ~data_rst & (state_ff == ST_EOB)
                & ((n_ff != 6'h00) | bs2_ff[BS2_EMPTY_KEEP_BIT]);

  always_comb begin
    mem_we    = 1'b0;
    mem_wofs  = 6'h00;
    mem_wdata = 32'h00000000;
    if (data_take) begin
      mem_we    = 1'b1;
      mem_wofs  = n_ff + 6'h01;
      mem_wdata[WORD_TAG_LSB+:3]  = TAG_DATA;
      mem_wdata[DATA_CHAN_LSB+:5] = i_conv.chan;
      mem_wdata[DATA_UNDER_BIT]   = under;
      mem_wdata[DATA_OVF_BIT]     = i_conv.overflow;
      mem_wdata[11:0]             = i_conv.value;
    end else if (state_ff == ST_HDR && !data_rst) begin
      mem_we    = 1'b1;
      mem_wdata[WORD_TAG_LSB+:3]  = TAG_HEADER;
      mem_wdata[HDR_COUNT_LSB+:6] = n_ff;
    end else if (state_ff == ST_EOB && !data_rst) begin
      mem_we    = 1'b1;
      mem_wofs  = n_ff + 6'h01;
      mem_wdata[WORD_TAG_LSB+:3]  = TAG_EOB;
      mem_wdata[23:0]             = gate_cnt_ff;
    end
  end

  // Flip-flop event store, one slot per event
  logic [31:0] mem_ff [NUM_EVENTS][SLOT_WORDS];
  always_ff @(posedge i_mclk) begin
    if (i_ce && mem_we) mem_ff[wp_ff][mem_wofs] <= mem_wdata;
    if (i_ce && wp_adv) len_ff[wp_ff] <= n_ff + 6'h02;
  end

  //==========================================================================
  // Register read port
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    if (i_reg_addr <= OFS_EVENT_BUF_END) begin
      if (empty) rd_val[WORD_TAG_LSB+:3] = TAG_INVALID;
      else rd_val = mem_ff[rp_ev_ff][rp_word_ff];
    end else if (i_reg_addr >= OFS_THRESH && i_reg_addr <= OFS_THRESH_END) begin
      rd_val[15:0] = thr_mem[i_reg_addr[5:1]];
    end else if (hit(i_reg_addr, OFS_STATUS1)) begin
      rd_val[ST1_READY_BIT]       = ~empty;
      rd_val[ST1_BUSY_BIT]        = busy;
      rd_val[ST1_GLOBAL_BUSY_BIT] = busy | chain_busy_s;
      rd_val[ST1_FULL_BIT]        = full;
      rd_val[ST1_EMPTY_BIT]       = empty;
    end else if (hit(i_reg_addr, OFS_BIT_SET1)) rd_val[15:0] = bs1_ff;
    else if (hit(i_reg_addr, OFS_CONTROL1)) rd_val[15:0] = cr1_ff;
    else if (hit(i_reg_addr, OFS_BIT_SET2)) rd_val[15:0] = bs2_ff;
    else if (hit(i_reg_addr, OFS_FC_WINDOW)) rd_val[15:0] = fcw_ff;
    else if (hit(i_reg_addr, OFS_GATE_CNT_LOW)) rd_val[15:0] = gate_cnt_ff[15:0];
    else if (hit(i_reg_addr, OFS_GATE_CNT_HIGH)) rd_val[7:0] = gate_cnt_ff[23:16];
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= 32'h00000000;
      o_reg_ack    <= 1'b0;
      o_data_ready <= 1'b0;
      o_busy_out   <= 1'b0;
      o_busy_oe    <= 1'b0;
      o_peak_clear <= 1'b0;
    end else if (i_ce) begin
      o_reg_ack    <= i_reg_rd | i_reg_wr;
      if (i_reg_rd) o_reg_rdata <= rd_val;
      o_data_ready <= ~empty;
      o_busy_out   <= busy;
      o_busy_oe    <= busy;
      o_peak_clear <= data_rst | (state_ff == ST_CLEAR);
    end
  end

  //==========================================================================
  // Checks
  a_kill_blocks: assert property (@(posedge i_mclk) disable iff (i_rst)
    data_take |-> !thr_entry[THR_KILL_BIT]) else $error("killed channel stored");
  a_under_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    data_take |-> mem_wdata[DATA_UNDER_BIT] == under) else $error("under flag wrong");
  a_under_drop: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_ff == ST_CONV && i_conv_valid && under && !bs2_ff[BS2_BELOW_KEEP_BIT]) |-> !mem_we)
    else $error("under value kept");
  a_ovf_drop: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_ff == ST_CONV && i_conv_valid && i_conv.overflow && !bs2_ff[BS2_OVF_KEEP_BIT]) |-> !mem_we)
    else $error("overflow value kept");
  a_full_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
    (wp_ff == rp_ev_ff && last_wr_ff) |-> busy && !empty) else $error("full not busy");
  a_gate_ignored: assert property (@(posedge i_mclk) disable iff (i_rst)
    (busy && gate_rise) |=> !(state_ff == ST_GATE && $past(state_ff) == ST_IDLE))
    else $error("gate taken while busy");
  a_clear_hold: assert property (@(posedge i_mclk) disable iff (i_rst || !i_ce)
    (i_ce && fc_hit && !data_rst) |=> (state_ff == ST_CLEAR)[*8]) else $error("clear cycle cut short");
  a_count_all: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && gate_rise && bs2_ff[BS2_COUNT_ALL_BIT] && !data_rst) |=> gate_cnt_ff == $past(gate_cnt_ff) + 24'h000001)
    else $error("gate not counted");
  a_data_reset: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_ce && data_rst) |=> (wp_ff == 5'h00 && rp_ev_ff == 5'h00 && gate_cnt_ff == 24'h000000))
    else $error("data reset incomplete");
  a_eob_count: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mem_we && state_ff == ST_EOB) |-> mem_wdata[23:0] == gate_cnt_ff) else $error("end word count wrong");

endmodule : arc_acq_ctrl

// ==== verif/arc_conv_model.sv ====
// Behavioural converter that streams values after each conversion start
`timescale 1ns/10ps
module arc_conv_model
  import arc_pkg::*;
(
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  input  wire logic            i_conv_start,
  input  wire arc_conv_s [3:0] i_vals,
  input  wire logic      [2:0] i_cnt,
  output logic                 o_conv_valid,
  output arc_conv_s            o_conv,
  output logic                 o_conv_done
);
  int unsigned idx = 0;
  logic        run = 1'b0;
  initial begin
    o_conv_valid = 1'b0;
    o_conv       = '0;
    o_conv_done  = 1'b0;
  end
  //==========================================================================
  // Stream
  always @(posedge i_mclk or posedge i_rst) begin
    o_conv_valid <= 1'b0;
    o_conv_done  <= 1'b0;
    // Junk between samples so a stale value never passes for a new one
    o_conv       <= ~o_conv;
    if (i_rst) begin
      run = 1'b0;
    end else if (i_conv_start) begin
      run = 1'b1;
      idx = 0;
    end else if (run && idx < i_cnt) begin
      o_conv_valid <= 1'b1;
      o_conv       <= i_vals[idx];
      idx++;
    end else if (run) begin
      o_conv_done <= 1'b1;
      run = 1'b0;
    end
  end
endmodule : arc_conv_model

// ==== verif/tb.sv ====
// Self-checking bench for the acquisition control block
`timescale 1ns/10ps
module tb;
  import arc_pkg::*;
  localparam logic [31:0] MH = 32'h0700_3F00;
  localparam logic [31:0] MD = 32'h071F_3FFF;
  localparam logic [31:0] ME = 32'h07FF_FFFF;
  logic            clk  = 1'b0;
  logic            rst  = 1'b1;
  logic            wr   = 1'b0;
  logic            rd   = 1'b0;
  logic            gate = 1'b0;
  logic            fcl  = 1'b0;
  logic            veto = 1'b0;
  logic            prst = 1'b0;
  logic            bsyl = 1'b0;
  logic            jmp  = 1'b0;
  logic     [15:0] addr = 16'h0000;
  logic     [15:0] wd   = 16'h0000;
  logic     [31:0] rdat, rdata;
  logic            ack, busy, boe, drdy, cstart, pclr, cvalid, cdone;
  arc_conv_s       conv;
  arc_conv_s [3:0] vals = '0;
  logic      [2:0] cnt  = 3'h0;
  int              bad_count = 0;
  int              samples_checked = 0;
  always #2.5 clk = ~clk;
  arc_acq_ctrl i_dut (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_gate(gate), .i_veto(veto),
    .i_fast_clear_input(fcl), .i_panel_reset(prst), .i_busy_line(bsyl), .i_stop_scope_jumper(jmp),
    .i_conv_valid(cvalid), .i_conv(conv), .i_conv_done(cdone), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_ack(ack), .o_busy_out(busy),
    .o_busy_oe(boe), .o_data_ready(drdy), .o_conv_start(cstart), .o_peak_clear(pclr));
  arc_conv_model i_conv (.i_mclk(clk), .i_rst(rst), .i_conv_start(cstart), .i_vals(vals), .i_cnt(cnt),
    .o_conv_valid(cvalid), .o_conv(conv), .o_conv_done(cdone));
  //==========================================================================
  // Tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    wr   = w;
    rd   = ~w;
    addr = a;
    wd   = d;
    @(posedge clk);
    #1;
    wr   = 1'b0;
    rd   = 1'b0;
    rdat = rdata;
    chk("ack", 32'h1, {31'h0, ack});
  endtask : bus
  task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    chk(n, e, rdat & m);
  endtask : rchk
  task automatic wait_pc(input logic lv);
    int k;
    k = 0;
    while (pclr !== lv && k < 1000) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("peak_clear", {31'h0, lv}, {31'h0, pclr});
  endtask : wait_pc
  task automatic trig(input logic fc, input logic [2:0] n);
    cnt = n;
    @(posedge clk);
    #1;
    gate = 1'b1;
    repeat (8) @(posedge clk);
    rchk("busy_bits", OFS_STATUS1, 32'h000C, 32'h000C);
    chk("busy_pin", 32'h1, {31'h0, busy});
    chk("busy_oe", 32'h1, {31'h0, boe});
    fcl = fc;
    repeat (6) @(posedge clk);
    #1;
    gate = 1'b0;
    fcl  = 1'b0;
    // Clear phase closes every event, aborted or not
    wait_pc(1'b1);
    wait_pc(1'b0);
  endtask : trig
  task automatic pulse(input logic g, input logic p);
    @(posedge clk);
    #1;
    gate = g;
    prst = p;
    repeat (8) @(posedge clk);
    #1;
    gate = 1'b0;
    prst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask : pulse
  //==========================================================================
  // Tests
  initial begin
    #300000;
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk("bs2", OFS_BIT_SET2, 32'hFFFF, 32'h4000);
    rchk("fcw", OFS_FC_WINDOW, 32'hFFFF, 32'h00C8);
    rchk("empty", OFS_STATUS1, 32'h0030, 32'h0020);
    rchk("unmapped", 16'h1FF0, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, OFS_THRESH, 16'h0010);
    bus(1'b1, OFS_THRESH + 16'h0002, 16'h0100);
    bus(1'b1, OFS_THRESH + 16'h0004, 16'h0010);
    bus(1'b1, OFS_THRESH + 16'h0006, 16'h0000);
    bus(1'b1, OFS_BIT_SET2, 16'h0800);
    vals = {1'b1, 5'h03, 12'h050, 1'b0, 5'h02, 12'h0FF, 1'b0, 5'h01, 12'hFFF, 1'b0, 5'h00, 12'h100};
    trig(1'b0, 3'h4);
    bus(1'b1, OFS_BIT_SET2, 16'h0118);
    vals = {1'b1, 5'h03, 12'h005, 1'b0, 5'h01, 12'h800, 1'b0, 5'h02, 12'h020, 1'b0, 5'h00, 12'h01F};
    trig(1'b0, 3'h4);
    bus(1'b1, OFS_BIT_CLEAR2, 16'h0118);
    bus(1'b1, OFS_BIT_SET2, 16'h1000);
    vals[0] = {1'b0, 5'h01, 12'h123};
    trig(1'b0, 3'h1);
    trig(1'b1, 3'h4);
    $display("acquisition done");
    rchk("hdr", OFS_EVENT_BUF, MH, 32'h0200_0100);
    rchk("dat", OFS_EVENT_BUF, MD, 32'h0000_0100);
    rchk("eob", OFS_EVENT_BUF, ME, 32'h0400_0001);
    rchk("hdr", OFS_EVENT_BUF, MH, 32'h0200_0300);
    rchk("dat", OFS_EVENT_BUF, MD, 32'h0000_201F);
    rchk("dat", OFS_EVENT_BUF, MD, 32'h0002_0020);
    rchk("dat", OFS_EVENT_BUF, MD, 32'h0003_1005);
    rchk("eob", OFS_EVENT_BUF, ME, 32'h0400_0002);
    rchk("hdr", OFS_EVENT_BUF, MH, 32'h0200_0000);
    rchk("eob", OFS_EVENT_BUF, ME, 32'h0400_0003);
    rchk("none", OFS_EVENT_BUF, 32'h0700_0000, 32'h0600_0000);
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0004);
    rchk("cnt_hi", OFS_GATE_CNT_HIGH, 32'hFFFF, 32'h0000);
    $display("readout done");
    for (int i = 0; i < 32; i++) begin
      trig(1'b0, 3'h0);
    end
    rchk("full", OFS_STATUS1, 32'h0034, 32'h0014);
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0024);
    chk("drdy", 32'h1, {31'h0, drdy});
    pulse(1'b1, 1'b0);
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0025);
    rchk("full", OFS_STATUS1, 32'h0034, 32'h0014);
    bus(1'b1, OFS_BIT_SET2, 16'h0004);
    bus(1'b1, OFS_BIT_CLEAR2, 16'h0004);
    rchk("empty", OFS_STATUS1, 32'h0034, 32'h0020);
    chk("drdy", 32'h0, {31'h0, drdy});
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0000);
    rchk("bs2", OFS_BIT_SET2, 32'hFFFF, 32'h5800);
    $display("full and data reset done");
    bus(1'b1, OFS_FC_WINDOW, 16'h0010);
    bus(1'b1, OFS_SINGLE_RESET, 16'h0000);
    rchk("fcw", OFS_FC_WINDOW, 32'hFFFF, 32'h00C8);
    rchk("bs2", OFS_BIT_SET2, 32'hFFFF, 32'h4000);
    rchk("thr", OFS_THRESH + 16'h0002, 32'h01FF, 32'h0100);
    $display("software reset done");
    bus(1'b1, OFS_BIT_CLEAR2, 16'h4000);
    veto = 1'b1;
    pulse(1'b1, 1'b0);
    veto = 1'b0;
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0000);
    bsyl = 1'b1;
    jmp  = 1'b1;
    pulse(1'b1, 1'b0);
    rchk("gbusy", OFS_STATUS1, 32'h000C, 32'h0008);
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0000);
    jmp = 1'b0;
    trig(1'b0, 3'h0);
    bsyl = 1'b0;
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0001);
    pulse(1'b0, 1'b1);
    rchk("cnt_lo", OFS_GATE_CNT_LOW, 32'hFFFF, 32'h0000);
    bus(1'b1, OFS_CONTROL1, 16'h0010);
    bus(1'b1, OFS_BIT_SET2, 16'h0800);
    pulse(1'b0, 1'b1);
    rchk("bs2", OFS_BIT_SET2, 32'hFFFF, 32'h4000);
    $display("panel, veto and chain done");
    test_done();
  end
endmodule : tb
